//--- common/rui_defs.svh
/*
 * Constants of the remote upgrade image controller: field positions,
 * widths, reset values and watchdog count layout.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Notes on behaviour
// [RL1] Power-up loads factory image from page zero
// [RL2] Application start may be any sector boundary
// [RL3] System should not share pages between images
// [RL4] Factory image reloads automatically after errors
// [RL5] Watchdog stays off while factory image active
// [RL6] Factory image sets next watchdog enable, timeout
// [RL7] Healthy application restarts watchdog before timeout
// [RL8] Watchdog expiry records cause, reloads factory image
// [RL9] Cause written on pin, CRC, watchdog, reset
// [RL10] Factory reads cause, then writes next selection
// [RL11] Application triggers factory reload after storing image; the code loads the update register contents instead
// [RL12] Shift register reaches update, status, control
// [RL13] Control holds page, watchdog settings, application flag
// [RL14] Application read copies control into shift register
// [RL15] Reconfiguration start copies update into control
// [RL16] Update changes only in factory, via update
// [RL17] Factory capture copies update into shift register
// [RL18] Status records cause; capture copies it out
// [RL19] Control, status, watchdog run on core clock
// [RL20] Shift, update registers follow user shift clock
// [RL21] Layout: flag, page, enable, 12-bit timeout
// [RL22] Watchdog count is timeout field, seventeen zeros
// [RL23] Cause bits: CRC, pin, fabric, reset, watchdog
// [RL24] Application flag set: control read only
// [RL25] Shift-select high shifts, low loads parallel
// [RL26] Low restart input reloads watchdog counter
// [RL27] Capture/update select stable around operation
`ifndef RUI_DEFS_SVH
`define RUI_DEFS_SVH

`define RUI_PAGE_W        24
`define RUI_WD_FIELD_W    12
`define RUI_WD_ZERO_W     17
`define RUI_WD_CNT_W      29
`define RUI_CTL_W         38
`define RUI_CAUSE_W       5
`define RUI_SHIFT_W       43

`define RUI_BIT_APP       0
`define RUI_BIT_WATCHDOG_ENABLE_BIT     25
`define RUI_BIT_CRC       0
`define RUI_BIT_PIN       1
`define RUI_BIT_FABRIC    2
`define RUI_BIT_EXT       3
`define RUI_BIT_WD        4

`define RUI_CTL_RESET     38'h00_0000_0000
`define RUI_CAUSE_RESET   5'h00

`endif

//--- common/rui_pkg.sv
/*
 * Types of the remote upgrade image controller.
 * Assumes rui_defs.svh is on the include path.
 */
`include "rui_defs.svh"

package rui_pkg;

    // Control and update share this layout, MSB first
    typedef struct packed {
        logic [`RUI_WD_FIELD_W-1:0] wd_timeout;
        logic                       wd_enable;
        logic [`RUI_PAGE_W-1:0]     page;
        logic                       app;
    } rui_ctl_t;

    typedef struct packed {
        logic wd;
        logic ext_pin;
        logic fabric;
        logic status_pin;
        logic crc;
    } rui_cause_t;

endpackage

//--- src/rui_ctrl.sv
/*
 * Remote upgrade image controller: control, update, status and shift
 * registers, user watchdog and reconfiguration sequencing.
 * Assumes all inputs are synchronous to core_clk; user_shift_clock is
 * sampled and its rising edge acts as the shift/update strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rui_defs.svh"

module rui_ctrl (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        user_shift_clock,
    input  wire logic                        shift_serial_in,
    input  wire logic                        shift_not_load_select,
    input  wire logic                        capture_not_update_select,
    input  wire logic                        fabric_reconfig_request_n,
    input  wire logic                        ext_reconfig_pin_n,
    input  wire logic                        config_status_pin_n,
    input  wire logic                        crc_error,
    input  wire logic                        watchdog_restart_n,
    output logic                             shift_serial_out,
    output logic                             reconfig_start,
    output logic [`RUI_PAGE_W-1:0]           start_page_address,
    output logic                             app_active,
    output logic                             watchdog_running,
    output rui_pkg::rui_cause_t              reconfig_cause
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rui_pkg::rui_ctl_t            ctl_r;
    rui_pkg::rui_ctl_t            ctl_nxt;
    rui_pkg::rui_ctl_t            upd_r;
    rui_pkg::rui_cause_t          cause_r;
    rui_pkg::rui_cause_t          cause_nxt;
    logic [`RUI_SHIFT_W-1:0]      shift_r;
    logic [`RUI_WD_CNT_W-1:0]     wd_cnt_r;
    logic                         uclk_prev_r;
    logic                         fab_prev_r;
    logic                         start_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Both strobes arrive as levels; a step is the first sampled cycle at the new level
    function automatic logic edge_up(input logic was_v, input logic now_v);
        edge_up = now_v & ~was_v;
    endfunction

    wire                          uclk_rise  = edge_up(uclk_prev_r, user_shift_clock);
    wire                          fab_fall   = edge_up(~fab_prev_r, ~fabric_reconfig_request_n);
    wire                          wd_on      = ctl_r.app & ctl_r.wd_enable; // RL5 RL24
    wire [`RUI_WD_CNT_W-1:0]      wd_reload  = {ctl_r.wd_timeout,
                                                {`RUI_WD_ZERO_W{1'b0}}}; // RL22
    // The count still holds the old image's value in the cycle after a load
    wire                          wd_expire  = wd_on & ~start_r & (wd_cnt_r == '0)
                                               & watchdog_restart_n; // RL8
    wire                          ev_ext     = ~ext_reconfig_pin_n;
    wire                          ev_pin     = ~config_status_pin_n;
    wire                          ev_any     = ev_ext | ev_pin | crc_error | wd_expire | fab_fall;

    // Application reads see control; factory captures see update
    wire rui_pkg::rui_ctl_t       cap_src    = ctl_r.app ? ctl_r : upd_r; // RL14 RL17
    wire [`RUI_SHIFT_W-1:0]       cap_word   = {cause_r, cap_src}; // RL18 RL12

    // Shift port operations, one per user clock step
    wire                          op_shift   = uclk_rise & shift_not_load_select; // RL25
    wire                          op_capture = uclk_rise & ~shift_not_load_select
                                               & capture_not_update_select; // RL25
    // Updates from an application image are dropped, not queued
    wire                          op_update  = uclk_rise & ~shift_not_load_select
                                               & ~capture_not_update_select
                                               & ~ctl_r.app; // RL16 RL24

    // One cause per reconfiguration; external reset outranks the rest
    always_comb begin
        cause_nxt = '0;
        ctl_nxt   = `RUI_CTL_RESET; // RL4
        if (ev_ext) begin
            cause_nxt.ext_pin = 1'b1; // RL9
        end else if (ev_pin) begin
            cause_nxt.status_pin = 1'b1; // RL9
        end else if (crc_error) begin
            cause_nxt.crc = 1'b1; // RL9
        end else if (wd_expire) begin
            cause_nxt.wd = 1'b1; // RL8
        end else begin
            cause_nxt.fabric = 1'b1; // RL9
            // Any sector-aligned page is taken as written
            ctl_nxt = upd_r; // RL15 RL2
        end
    end

    // ------------------------------------------------------------
    // Core-clock registers (control, status, watchdog)
    // ------------------------------------------------------------
    // Control is written only by the sequencer, never by the shift port
    always_ff @(posedge core_clk) begin // RL19
        if (rst) begin
            ctl_r <= `RUI_CTL_RESET; // RL1
        end else if (ev_any) begin
            ctl_r <= ctl_nxt; // RL13
        end
    end

    // Status is one-hot and overwritten by each event, not sticky
    always_ff @(posedge core_clk) begin // RL19
        if (rst) begin
            cause_r <= `RUI_CAUSE_RESET;
        end else if (ev_any) begin
            cause_r <= cause_nxt; // RL18 RL23
        end
    end

    // Set in reset so that leaving reset looks like a factory load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_r <= 1'b1; // RL1
        end else begin
            start_r <= ev_any; // RL4
        end
    end

    // Restart is a level: holding it low keeps the count full
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wd_cnt_r <= '0;
        end else if (start_r || !watchdog_restart_n || !wd_on) begin
            wd_cnt_r <= wd_reload; // RL26
        end else if (wd_cnt_r != '0) begin
            wd_cnt_r <= wd_cnt_r - 1'b1; // RL7
        end
    end

    // ------------------------------------------------------------
    // Shift and update registers, stepped by user shift clock
    // ------------------------------------------------------------
    // Reset values match the idle pin levels, so no false step follows reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            uclk_prev_r <= 1'b0;
            fab_prev_r  <= 1'b1;
        end else begin
            uclk_prev_r <= user_shift_clock;
            fab_prev_r  <= fabric_reconfig_request_n;
        end
    end

    // Data enters at the top and leaves at bit 0, least significant first
    always_ff @(posedge core_clk) begin // RL20
        if (rst) begin
            shift_r <= '0;
        end else if (op_shift) begin
            shift_r <= {shift_serial_in, shift_r[`RUI_SHIFT_W-1:1]}; // RL25
        end else if (op_capture) begin
            shift_r <= cap_word; // RL25 RL12
        end
    end

    // The status bits on top of the shift word are not written back
    always_ff @(posedge core_clk) begin // RL20
        if (rst) begin
            upd_r <= `RUI_CTL_RESET;
        end else if (op_update) begin
            upd_r <= shift_r[`RUI_CTL_W-1:0]; // RL16 RL21
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Serial data out lags the shift register by one core cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_serial_out <= 1'b0;
        end else begin
            shift_serial_out <= shift_r[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reconfig_start <= 1'b0;
        end else begin
            reconfig_start <= start_r; // RL4
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_page_address <= '0;
            app_active         <= 1'b0;
        end else begin
            start_page_address <= ctl_r.page; // RL1 RL2
            app_active         <= ctl_r.app; // RL13
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            watchdog_running <= 1'b0;
        end else begin
            watchdog_running <= wd_on; // RL5
        end
    end

    // Cause bit order is fixed by the package struct
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reconfig_cause <= `RUI_CAUSE_RESET;
        end else begin
            reconfig_cause <= cause_r; // RL23
        end
    end

endmodule

`default_nettype wire

//--- testbench/rui_ctrl_props.sv
/* Port checker for rui_ctrl.
   Assumes rui_pkg is compiled first; bound to every rui_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module rui_ctrl_props (
    input wire logic                core_clk,
    input wire logic                rst,
    input wire logic                user_shift_clock,
    input wire logic                shift_serial_in,
    input wire logic                shift_not_load_select,
    input wire logic                capture_not_update_select,
    input wire logic                fabric_reconfig_request_n,
    input wire logic                ext_reconfig_pin_n,
    input wire logic                config_status_pin_n,
    input wire logic                crc_error,
    input wire logic                watchdog_restart_n,
    input wire logic                shift_serial_out,
    input wire logic                reconfig_start,
    input wire logic [23:0]         start_page_address,
    input wire logic                app_active,
    input wire logic                watchdog_running,
    input wire rui_pkg::rui_cause_t reconfig_cause
);
    logic fab_q;
    wire  fab_fell = fab_q & ~fabric_reconfig_request_n;
    wire  quiet = ext_reconfig_pin_n & config_status_pin_n & ~crc_error & ~fab_fell;
    always_ff @(posedge core_clk) fab_q <= rst | fabric_reconfig_request_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_ext_zero: assert property (!ext_reconfig_pin_n |-> ##2 reconfig_cause == 5'h08
        && start_page_address == 24'h000000 && !app_active) else $error("ext cause wrong");
    chk_pin_cause: assert property (!config_status_pin_n && ext_reconfig_pin_n
        |-> ##2 reconfig_cause == 5'h02) else $error("status pin cause wrong");
    chk_crc_factory: assert property (crc_error && ext_reconfig_pin_n && config_status_pin_n
        |-> ##2 reconfig_cause == 5'h01 && !app_active) else $error("crc fallback wrong");
    chk_fabric_load: assert property (fab_fell && !watchdog_running && (quiet | fab_fell)
        && ext_reconfig_pin_n && config_status_pin_n && !crc_error
        |-> ##2 reconfig_cause == 5'h04 && reconfig_start) else $error("fabric load wrong");
    chk_wd_factory: assert property (!app_active |-> !watchdog_running)
        else $error("watchdog runs in factory");
    chk_quiet_hold: assert property (quiet && $past(quiet) && !watchdog_running
        |=> $stable(start_page_address) && $stable(app_active)) else $error("control moved");
    chk_app_entry: assert property ($rose(app_active) |-> $past(fab_fell, 2))
        else $error("app flag set without fabric load");
    chk_restart_hold: assert property ((!watchdog_restart_n && quiet) [*3]
        ##0 watchdog_running |=> watchdog_running) else $error("watchdog fired on restart");
endmodule
bind rui_ctrl rui_ctrl_props u_props (.*);
`default_nettype wire

//--- testbench/rui_ctrl_tb_top.sv
/* Bench for rui_ctrl: shift traffic, fabric load, watchdog, triggers.
   Assumes rui_pkg, the fabric model and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module rui_ctrl_tb_top;
    localparam logic [37:0] UPD_W = {12'h000, 1'b1, 24'h0a5a5a, 1'b1};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fab_n = 1'b1;
    logic ext_n = 1'b1;
    logic stat_n = 1'b1;
    logic crc = 1'b0;
    logic wd_n = 1'b0;
    logic uclk, sdi, snl, cnu, sso, rs, app, wdr;
    logic [23:0] page;
    rui_pkg::rui_cause_t cause;
    logic [42:0] w;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    always #12.5 core_clk = ~core_clk;
    rui_fabric P (.core_clk(core_clk), .user_shift_clock(uclk), .shift_serial_in(sdi),
        .shift_not_load_select(snl), .capture_not_update_select(cnu));
    rui_ctrl DUT (.core_clk(core_clk), .rst(rst), .user_shift_clock(uclk),
        .shift_serial_in(sdi), .shift_not_load_select(snl), .capture_not_update_select(cnu),
        .fabric_reconfig_request_n(fab_n), .ext_reconfig_pin_n(ext_n),
        .config_status_pin_n(stat_n), .crc_error(crc), .watchdog_restart_n(wd_n),
        .shift_serial_out(sso), .reconfig_start(rs), .start_page_address(page),
        .app_active(app), .watchdog_running(wdr), .reconfig_cause(cause));
    task automatic test_done();
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string what, input logic [42:0] got, input logic [42:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            test_done();
        end
    end
    task automatic ctl(input logic [23:0] p, input logic a, input logic r);
        check("page", page, p);
        check("app", app, a);
        check("wd_run", wdr, r);
    endtask
    task automatic fire(input int k, input logic [4:0] exp);
        @(posedge core_clk);
        fab_n <= (k != 0);
        ext_n <= (k != 1);
        stat_n <= (k != 2);
        crc <= (k == 3);
        @(posedge core_clk);
        {fab_n, ext_n, stat_n, crc} <= 4'he;
        @(posedge core_clk);
        #1 check("start", rs, 1'b1);
        check("cause", cause, exp);
    endtask
    task automatic write_upd(input logic [37:0] v);
        for (int i = 0; i < 43; i++) P.step(1'b1, 1'b0, i < 38 ? v[i] : 1'b0);
        P.step(1'b0, 1'b0, 1'b0);
    endtask
    task automatic read_word();
        P.step(1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 43; i++) begin
            @(negedge core_clk);
            @(negedge core_clk);
            w[i] = sso;
            P.step(1'b1, 1'b0, 1'b0);
        end
    endtask
    task automatic t_power_up();
        logic seen;
        seen = 1'b0;
        repeat (4) begin
            @(negedge core_clk);
            seen |= rs;
        end
        check("boot", seen, 1'b1);
        ctl(24'h000000, 1'b0, 1'b0);
    endtask
    task automatic t_app_cycle();
        write_upd(UPD_W);
        fire(0, 5'h04);
        ctl(24'h0a5a5a, 1'b1, 1'b1);
        read_word();
        check("app_read", w, {5'h04, UPD_W});
        write_upd(38'h0);
        fire(0, 5'h04);
        ctl(24'h0a5a5a, 1'b1, 1'b1);
    endtask
    task automatic t_wd_expiry();
        @(posedge core_clk);
        wd_n <= 1'b1;
        for (int i = 0; i < 20 && app === 1'b1; i++) @(negedge core_clk);
        check("wd_cause", cause, 5'h10);
        ctl(24'h000000, 1'b0, 1'b0);
        read_word();
        check("fac_read", w, {5'h10, UPD_W});
    endtask
    task automatic t_triggers();
        fire(1, 5'h08);
        fire(2, 5'h02);
        fire(3, 5'h01);
        ctl(24'h000000, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_power_up();
        t_app_cycle();
        t_wd_expiry();
        t_triggers();
        test_done();
    end
endmodule
`default_nettype wire

//--- testbench/rui_fabric.sv
/* Fabric-side model: user logic stepping the shift port.
   Assumes the bench calls step between core clock edges. */
`timescale 1ns/1ps
`default_nettype none
module rui_fabric (
    input  wire logic core_clk,
    output logic      user_shift_clock,
    output logic      shift_serial_in,
    output logic      shift_not_load_select,
    output logic      capture_not_update_select
);
    initial begin
        user_shift_clock = 1'b0;
        shift_serial_in = 1'b0;
        shift_not_load_select = 1'b1;
        capture_not_update_select = 1'b1;
    end
    // Mode and data settle a cycle before the clock rises and then hold
    task automatic step(input logic shf, input logic cap, input logic din);
        @(posedge core_clk);
        shift_not_load_select <= shf;
        capture_not_update_select <= cap;
        shift_serial_in <= din;
        @(posedge core_clk);
        user_shift_clock <= 1'b1;
        @(posedge core_clk);
        user_shift_clock <= 1'b0;
        shift_serial_in <= ~din; // Stale data never lingers on the line
    endtask
endmodule
`default_nettype wire
